// ---- logic/plc_supp_pkg.sv ----
package plc_supp_pkg;
  localparam int WORD_W     = 16;
  localparam int BIT_IDX_W  = 4;
  localparam int WORD_NUM_W = 8;
  localparam int TC_NUM_W   = 7;
  localparam int OP_W       = 4;
  localparam int AREA_W     = 2;
  localparam int CAUSE_W    = 8;

  // highest timer or counter word number
  localparam logic [WORD_NUM_W-1:0] TC_WORD_MAX = 8'h7F;

  // instruction codes
  localparam logic [OP_W-1:0] OP_HALT     = 4'h0;
  localparam logic [OP_W-1:0] OP_NO_EFFECT = 4'h1;
  localparam logic [OP_W-1:0] OP_DISPLAY  = 4'h2;
  localparam logic [OP_W-1:0] OP_LOAD_SYS = 4'h3;
  localparam logic [OP_W-1:0] OP_ENABLE   = 4'h4;
  localparam logic [OP_W-1:0] OP_TEST_ONE = 4'h5;
  localparam logic [OP_W-1:0] OP_TEST_ZERO = 4'h6;
  localparam logic [OP_W-1:0] OP_SET_BIT  = 4'h7;
  localparam logic [OP_W-1:0] OP_CLR_BIT  = 4'h8;

  // operand areas
  localparam logic [AREA_W-1:0] AREA_TIMER   = 2'h0;
  localparam logic [AREA_W-1:0] AREA_COUNTER = 2'h1;
  localparam logic [AREA_W-1:0] AREA_DATA    = 2'h2;
  localparam logic [AREA_W-1:0] AREA_SYSTEM  = 2'h3;

  // stop cause codes, values arbitrary
  localparam logic [CAUSE_W-1:0] CAUSE_NONE         = 8'h00;
  localparam logic [CAUSE_W-1:0] CAUSE_PROGRAM_STOP = 8'h01;

  localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_READ = 3'b010,
    ST_WAIT = 3'b100
  } state_t;
endpackage

// ---- logic/plc_supplementary_op_exec.sv ----
`timescale 1ns/100ps
`default_nettype none
module plc_supplementary_op_exec (
  // clock and reset
  input  wire logic                                   i_core_clk,
  input  wire logic                                   i_arst_n,
  // instruction from the scan engine
  input  wire logic                                   i_op_valid,
  input  wire logic [plc_supp_pkg::OP_W-1:0]          i_op_code,
  input  wire logic [plc_supp_pkg::AREA_W-1:0]        i_op_area,
  input  wire logic [plc_supp_pkg::WORD_NUM_W-1:0]    i_op_word,
  input  wire logic [plc_supp_pkg::BIT_IDX_W-1:0]     i_op_bit,
  input  wire logic                                   i_in_function_block,
  // scan and mode control
  input  wire logic                                   i_scan_end,
  input  wire logic                                   i_selector_to_run,
  input  wire logic                                   i_programmer_run,
  // logic result written by basic ops
  input  wire logic                                   i_rlo_wr,
  input  wire logic                                   i_rlo_in,
  // timer/counter start input level
  input  wire logic                                   i_tc_start_level,
  // operand memory read data, one cycle after o_mem_rd
  input  wire logic [plc_supp_pkg::WORD_W-1:0]        i_mem_rdata,
  // status
  output logic                                        o_busy,
  output logic                                        o_done,
  output logic                                        o_invalid,
  output logic                                        o_logic_result_bit,
  output logic [plc_supp_pkg::WORD_W-1:0]             o_primary_accumulator,
  output logic                                        o_running,
  output logic                                        o_halt_pending,
  output logic [plc_supp_pkg::CAUSE_W-1:0]            o_program_stop_cause,
  // operand memory
  output logic                                        o_mem_rd,
  output logic                                        o_mem_wr,
  output logic [plc_supp_pkg::AREA_W-1:0]             o_mem_area,
  output logic [plc_supp_pkg::WORD_NUM_W-1:0]         o_mem_word,
  output logic [plc_supp_pkg::WORD_W-1:0]             o_mem_wdata,
  // timer/counter enable
  output logic                                        o_tc_enable,
  output logic                                        o_tc_is_counter,
  output logic [plc_supp_pkg::TC_NUM_W-1:0]           o_tc_num
);

  function automatic logic [plc_supp_pkg::WORD_W-1:0] bit_mask(
    input logic [plc_supp_pkg::BIT_IDX_W-1:0] idx);
    bit_mask = plc_supp_pkg::WORD_W'(1) << idx;
  endfunction

  function automatic logic operand_ok(
    input logic [plc_supp_pkg::OP_W-1:0]       op,
    input logic [plc_supp_pkg::AREA_W-1:0]     area,
    input logic [plc_supp_pkg::WORD_NUM_W-1:0] word);
    logic tc;
    logic tc_fits;
    tc = (area == plc_supp_pkg::AREA_TIMER) || (area == plc_supp_pkg::AREA_COUNTER);
    tc_fits = !tc || (word <= plc_supp_pkg::TC_WORD_MAX);
    unique case (op)
      plc_supp_pkg::OP_LOAD_SYS: operand_ok = 1'b1;
      plc_supp_pkg::OP_ENABLE: operand_ok = tc && tc_fits;
      plc_supp_pkg::OP_TEST_ONE,
      plc_supp_pkg::OP_TEST_ZERO: operand_ok = tc_fits;
      plc_supp_pkg::OP_SET_BIT,
      plc_supp_pkg::OP_CLR_BIT:
        operand_ok = tc_fits && (area != plc_supp_pkg::AREA_SYSTEM);
      default: operand_ok = 1'b0;
    endcase
  endfunction

  plc_supp_pkg::state_t                       state_reg, state_next;
  logic [plc_supp_pkg::OP_W-1:0]              op_reg, op_next;
  logic [plc_supp_pkg::AREA_W-1:0]            area_reg, area_next;
  logic [plc_supp_pkg::WORD_NUM_W-1:0]        word_reg, word_next;
  logic [plc_supp_pkg::BIT_IDX_W-1:0]         bit_reg, bit_next;
  logic                                       rlo_reg, rlo_next;
  logic                                       rlo_prev_reg, rlo_prev_next;
  logic [plc_supp_pkg::WORD_W-1:0]            accu_reg, accu_next;
  logic                                       running_reg, running_next;
  logic                                       halt_reg, halt_next;
  logic [plc_supp_pkg::CAUSE_W-1:0]           cause_reg, cause_next;
  logic                                       busy_reg, busy_next;
  logic                                       done_reg, done_next;
  logic                                       invalid_reg, invalid_next;
  logic                                       mem_rd_reg, mem_rd_next;
  logic                                       mem_wr_reg, mem_wr_next;
  logic [plc_supp_pkg::WORD_W-1:0]            wdata_reg, wdata_next;
  logic                                       tc_en_reg, tc_en_next;
  logic                                       tc_cnt_reg, tc_cnt_next;
  logic [plc_supp_pkg::TC_NUM_W-1:0]          tc_num_reg, tc_num_next;
  logic                                       accept;

  // ops keep flowing while a halt is pending so the scan can finish
  assign accept = i_op_valid && (state_reg == plc_supp_pkg::ST_IDLE) && running_reg;

  always_comb begin
    state_next    = state_reg;
    op_next       = op_reg;
    area_next     = area_reg;
    word_next     = word_reg;
    bit_next      = bit_reg;
    rlo_next      = i_rlo_wr ? i_rlo_in : rlo_reg;
    rlo_prev_next = rlo_prev_reg;
    accu_next     = accu_reg;
    running_next  = running_reg;
    halt_next     = halt_reg;
    cause_next    = cause_reg;
    busy_next     = busy_reg;
    done_next     = 1'b0;
    invalid_next  = 1'b0;
    mem_rd_next   = 1'b0;
    mem_wr_next   = 1'b0;
    wdata_next    = wdata_reg;
    tc_en_next    = 1'b0;
    tc_cnt_next   = tc_cnt_reg;
    tc_num_next   = tc_num_reg;
    if (halt_reg && i_scan_end) begin
      running_next = 1'b0;
      halt_next    = 1'b0;
      cause_next   = plc_supp_pkg::CAUSE_PROGRAM_STOP;
    end else if (!running_reg && (i_selector_to_run || i_programmer_run)) begin
      running_next = 1'b1;
    end
    unique case (state_reg)
      plc_supp_pkg::ST_IDLE: begin
        if (accept) begin
          op_next   = i_op_code;
          area_next = (i_op_code == plc_supp_pkg::OP_LOAD_SYS) ?
                      plc_supp_pkg::AREA_SYSTEM : i_op_area;
          word_next = i_op_word;
          bit_next  = i_op_bit;
          if (i_op_code == plc_supp_pkg::OP_HALT) begin
            halt_next = 1'b1;
            done_next = 1'b1;
          end else if (i_op_code == plc_supp_pkg::OP_NO_EFFECT ||
                       i_op_code == plc_supp_pkg::OP_DISPLAY) begin
            done_next = 1'b1;
          end else if (!i_in_function_block ||
                       !operand_ok(i_op_code, i_op_area, i_op_word)) begin
            invalid_next = 1'b1;
          end else if (i_op_code == plc_supp_pkg::OP_ENABLE) begin
            // edge memory is one flag shared by all enable statements, sampled before any write
            rlo_prev_next = rlo_reg;
            tc_en_next    = rlo_reg && !rlo_prev_reg && i_tc_start_level;
            tc_cnt_next   = (i_op_area == plc_supp_pkg::AREA_COUNTER);
            tc_num_next   = i_op_word[plc_supp_pkg::TC_NUM_W-1:0];
            done_next     = 1'b1;
          end else begin
            mem_rd_next = 1'b1;
            busy_next   = 1'b1;
            state_next  = plc_supp_pkg::ST_READ;
          end
        end
      end
      plc_supp_pkg::ST_READ: state_next = plc_supp_pkg::ST_WAIT;
      plc_supp_pkg::ST_WAIT: begin
        state_next = plc_supp_pkg::ST_IDLE;
        busy_next  = 1'b0;
        done_next  = 1'b1;
        unique case (op_reg)
          plc_supp_pkg::OP_LOAD_SYS: accu_next = i_mem_rdata;
          // new string: the old result is overwritten, never combined
          plc_supp_pkg::OP_TEST_ONE:
            rlo_next = |(i_mem_rdata & bit_mask(bit_reg));
          plc_supp_pkg::OP_TEST_ZERO:
            rlo_next = ~|(i_mem_rdata & bit_mask(bit_reg));
          plc_supp_pkg::OP_SET_BIT: begin
            mem_wr_next = 1'b1;
            wdata_next  = i_mem_rdata | bit_mask(bit_reg);
          end
          plc_supp_pkg::OP_CLR_BIT: begin
            mem_wr_next = 1'b1;
            wdata_next  = i_mem_rdata & ~bit_mask(bit_reg);
          end
          default: done_next = 1'b1;
        endcase
      end
      default: state_next = plc_supp_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg    <= plc_supp_pkg::ST_IDLE;
      op_reg       <= plc_supp_pkg::OP_NO_EFFECT;
      area_reg     <= plc_supp_pkg::AREA_TIMER;
      word_reg     <= '0;
      bit_reg      <= '0;
      rlo_reg      <= 1'b0;
      rlo_prev_reg <= 1'b0;
      accu_reg     <= plc_supp_pkg::WORD_ZERO;
      running_reg  <= 1'b1;
      halt_reg     <= 1'b0;
      cause_reg    <= plc_supp_pkg::CAUSE_NONE;
      busy_reg     <= 1'b0;
      done_reg     <= 1'b0;
      invalid_reg  <= 1'b0;
      mem_rd_reg   <= 1'b0;
      mem_wr_reg   <= 1'b0;
      wdata_reg    <= plc_supp_pkg::WORD_ZERO;
      tc_en_reg    <= 1'b0;
      tc_cnt_reg   <= 1'b0;
      tc_num_reg   <= '0;
    end else begin
      state_reg    <= state_next;
      op_reg       <= op_next;
      area_reg     <= area_next;
      word_reg     <= word_next;
      bit_reg      <= bit_next;
      rlo_reg      <= rlo_next;
      rlo_prev_reg <= rlo_prev_next;
      accu_reg     <= accu_next;
      running_reg  <= running_next;
      halt_reg     <= halt_next;
      cause_reg    <= cause_next;
      busy_reg     <= busy_next;
      done_reg     <= done_next;
      invalid_reg  <= invalid_next;
      mem_rd_reg   <= mem_rd_next;
      mem_wr_reg   <= mem_wr_next;
      wdata_reg    <= wdata_next;
      tc_en_reg    <= tc_en_next;
      tc_cnt_reg   <= tc_cnt_next;
      tc_num_reg   <= tc_num_next;
    end
  end

  assign o_busy                = busy_reg;
  assign o_done                = done_reg;
  assign o_invalid             = invalid_reg;
  assign o_logic_result_bit    = rlo_reg;
  assign o_primary_accumulator = accu_reg;
  assign o_running             = running_reg;
  assign o_halt_pending        = halt_reg;
  assign o_program_stop_cause  = cause_reg;
  assign o_mem_rd              = mem_rd_reg;
  assign o_mem_wr              = mem_wr_reg;
  assign o_mem_area            = area_reg;
  assign o_mem_word            = word_reg;
  assign o_mem_wdata           = wdata_reg;
  assign o_tc_enable           = tc_en_reg;
  assign o_tc_is_counter       = tc_cnt_reg;
  assign o_tc_num              = tc_num_reg;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);

  a_halt_keeps_scan: assert property (
    o_halt_pending && o_running && !i_scan_end |=> o_running && o_halt_pending)
    else $error("halt left run before scan end");
  a_halt_at_end: assert property (
    o_halt_pending && i_scan_end |=> !o_running &&
      o_program_stop_cause == plc_supp_pkg::CAUSE_PROGRAM_STOP)
    else $error("scan end after halt did not stop");
  a_restart_run: assert property (
    !o_running && (i_selector_to_run || i_programmer_run) |=> o_running)
    else $error("stop not left on run command");
  a_skip_quiet: assert property (
    accept && !i_rlo_wr && (i_op_code == plc_supp_pkg::OP_NO_EFFECT ||
      i_op_code == plc_supp_pkg::OP_DISPLAY)
    |=> $stable(o_logic_result_bit) && $stable(o_primary_accumulator) &&
      !o_mem_rd && !o_mem_wr && o_done)
    else $error("skipped op had an effect");
  a_block_refuse: assert property (
    accept && !i_in_function_block && i_op_code >= plc_supp_pkg::OP_LOAD_SYS &&
      i_op_code <= plc_supp_pkg::OP_CLR_BIT |=> o_invalid && !o_mem_rd && !o_tc_enable)
    else $error("op outside function block accepted");
  a_load_accu: assert property (
    o_mem_rd && op_reg == plc_supp_pkg::OP_LOAD_SYS |=> ##1
      o_primary_accumulator == $past(i_mem_rdata) && o_done)
    else $error("system load wrong");
  a_enable_edge: assert property (
    o_tc_enable |-> $past(accept && i_op_code == plc_supp_pkg::OP_ENABLE &&
      i_in_function_block && o_logic_result_bit && !rlo_prev_reg && i_tc_start_level))
    else $error("enable without rising result");
  a_test_one: assert property (
    state_reg == plc_supp_pkg::ST_WAIT && op_reg == plc_supp_pkg::OP_TEST_ONE
    |=> o_logic_result_bit == $past(i_mem_rdata[bit_reg]))
    else $error("test for one wrong");
  a_test_zero: assert property (
    state_reg == plc_supp_pkg::ST_WAIT && op_reg == plc_supp_pkg::OP_TEST_ZERO
    |=> o_logic_result_bit == !$past(i_mem_rdata[bit_reg]))
    else $error("test for zero wrong");
  a_set_write: assert property (
    state_reg == plc_supp_pkg::ST_WAIT && op_reg == plc_supp_pkg::OP_SET_BIT && !i_rlo_wr
    |=> o_mem_wr && o_mem_wdata[bit_reg] && $stable(o_logic_result_bit))
    else $error("set bit wrong");
  a_clear_write: assert property (
    state_reg == plc_supp_pkg::ST_WAIT && op_reg == plc_supp_pkg::OP_CLR_BIT && !i_rlo_wr
    |=> o_mem_wr && !o_mem_wdata[bit_reg] && $stable(o_logic_result_bit))
    else $error("clear bit wrong");
  a_system_write: assert property (
    accept && i_in_function_block && i_op_area == plc_supp_pkg::AREA_SYSTEM &&
      (i_op_code == plc_supp_pkg::OP_SET_BIT || i_op_code == plc_supp_pkg::OP_CLR_BIT)
    |=> o_invalid && !o_mem_rd && !o_busy ##1 !o_mem_wr)
    else $error("write to system area accepted");

  c_program_stop: cover property (o_halt_pending ##[1:50] !o_running);
  c_test_bit: cover property (o_mem_rd && op_reg == plc_supp_pkg::OP_TEST_ZERO ##2 o_done);
  c_set_bit: cover property (o_mem_wr);
  c_enable: cover property (o_tc_enable && o_tc_is_counter);
endmodule
`default_nettype wire

// ---- dv/tb_plc_supplementary_op_exec.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_plc_supplementary_op_exec;
  logic        clk, arst_n, op_valid, in_fb, scan_end, sel_run, prog_run, rlo_wr, rlo_in;
  logic        tc_start;
  logic [3:0]  op_code, op_bit;
  logic [1:0]  op_area;
  logic [7:0]  op_word;
  logic [15:0] mem_rdata;
  logic        busy, done, inval, logic_result_bit, running, pend, mem_rd, mem_wr, tc_en, tc_cnt;
  logic [15:0] accu, wdata;
  logic [7:0]  cause, mem_word;
  logic [1:0]  mem_area;
  logic [6:0]  tc_num;
  logic        s_done, s_inv, s_tc, s_wr, s_rd, s_cnt;
  logic [15:0] s_wdata;
  logic [7:0]  s_word;
  logic [1:0]  s_area;
  logic [6:0]  s_num;
  int          errors, checks_done;

  plc_supplementary_op_exec DUT (
    .i_core_clk(clk), .i_arst_n(arst_n), .i_op_valid(op_valid), .i_op_code(op_code),
    .i_op_area(op_area), .i_op_word(op_word), .i_op_bit(op_bit),
    .i_in_function_block(in_fb), .i_scan_end(scan_end), .i_selector_to_run(sel_run),
    .i_programmer_run(prog_run), .i_rlo_wr(rlo_wr), .i_rlo_in(rlo_in),
    .i_tc_start_level(tc_start), .i_mem_rdata(mem_rdata), .o_busy(busy), .o_done(done),
    .o_invalid(inval), .o_logic_result_bit(logic_result_bit), .o_primary_accumulator(accu),
    .o_running(running), .o_halt_pending(pend), .o_program_stop_cause(cause),
    .o_mem_rd(mem_rd), .o_mem_wr(mem_wr), .o_mem_area(mem_area), .o_mem_word(mem_word),
    .o_mem_wdata(wdata), .o_tc_enable(tc_en), .o_tc_is_counter(tc_cnt), .o_tc_num(tc_num));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic set_rlo(input logic v);
    rlo_wr = 1'b1;
    rlo_in = v;
    @(posedge clk); #1;
    rlo_wr = 1'b0;
  endtask

  // bounded wait; latches what the completion cycle showed
  task automatic do_op(input logic [3:0] code, input logic [1:0] area, input logic [7:0] word,
                       input logic [3:0] bn, input logic [15:0] rdata);
    int n;
    op_code = code; op_area = area; op_word = word; op_bit = bn; mem_rdata = rdata;
    op_valid = 1'b1;
    @(posedge clk); #1;
    op_valid = 1'b0;
    {s_done, s_inv, s_tc, s_wr, s_rd} = '0;
    n = 0;
    // outputs of the taking edge are already up, so look before waiting
    while (n < 8) begin
      if (mem_rd === 1'b1) begin
        s_rd = 1'b1; s_area = mem_area; s_word = mem_word;
      end
      s_inv = (inval === 1'b1);
      if (done === 1'b1) begin
        s_done = 1'b1; s_tc = tc_en; s_wr = mem_wr; s_wdata = wdata; s_cnt = tc_cnt;
        s_num = tc_num;
      end
      if (s_done || s_inv) break;
      @(posedge clk); #1;
      n++;
    end
    if (!s_done && !s_inv) begin
      errors++;
      $display("unexpected op completion expected 1 seen 0");
      final_report();
    end
    // one idle edge keeps the next request off this time step
    @(posedge clk); #1;
  endtask

  task automatic t_bit_tests;
    set_rlo(1'b1);
    do_op(plc_supp_pkg::OP_TEST_ONE, plc_supp_pkg::AREA_DATA, 8'hFF, 4'hF, 16'h7FFF);
    chk("test one rlo", 16'h0000, {15'h0, logic_result_bit});
    chk("test one word", 16'h00FF, {8'h00, s_word});
    set_rlo(1'b0);
    do_op(plc_supp_pkg::OP_TEST_ZERO, plc_supp_pkg::AREA_SYSTEM, 8'hFF, 4'h0, 16'hFFFE);
    chk("test zero rlo", 16'h0001, {15'h0, logic_result_bit});
    chk("system area read", 16'h0003, {14'h0, s_area});
    do_op(plc_supp_pkg::OP_TEST_ONE, plc_supp_pkg::AREA_COUNTER, 8'h7F, 4'h7, 16'h0080);
    chk("test one bit set", 16'h0001, {15'h0, logic_result_bit});
    do_op(plc_supp_pkg::OP_TEST_ZERO, plc_supp_pkg::AREA_TIMER, 8'h00, 4'h7, 16'h0080);
    chk("test zero bit set", 16'h0000, {15'h0, logic_result_bit});
    $display("bit tests done");
  endtask

  task automatic t_set_clear;
    set_rlo(1'b0);
    do_op(plc_supp_pkg::OP_SET_BIT, plc_supp_pkg::AREA_DATA, 8'h03, 4'h4, 16'h0000);
    chk("set wdata", 16'h0010, s_wr ? s_wdata : 16'hDEAD);
    chk("set keeps rlo", 16'h0000, {15'h0, logic_result_bit});
    set_rlo(1'b1);
    do_op(plc_supp_pkg::OP_CLR_BIT, plc_supp_pkg::AREA_TIMER, 8'h7F, 4'hF, 16'hFFFF);
    chk("clear wdata", 16'h7FFF, s_wr ? s_wdata : 16'hDEAD);
    chk("clear keeps rlo", 16'h0001, {15'h0, logic_result_bit});
    $display("set and clear done");
  endtask

  task automatic t_load_skip;
    set_rlo(1'b0);
    do_op(plc_supp_pkg::OP_LOAD_SYS, plc_supp_pkg::AREA_DATA, 8'hC8, 4'h0, 16'hA5C3);
    chk("load accu", 16'hA5C3, accu);
    chk("load area", 16'h0003, {14'h0, s_area});
    set_rlo(1'b1);
    in_fb = 1'b0;
    for (int k = 0; k < 2; k++) begin
      do_op(k ? plc_supp_pkg::OP_DISPLAY : plc_supp_pkg::OP_NO_EFFECT,
            plc_supp_pkg::AREA_DATA, 8'h01, 4'h1, 16'h1234);
      chk("skip done", 16'h0001, {15'h0, s_done & ~s_rd});
      chk("skip accu", 16'hA5C3, accu);
      chk("skip rlo", 16'h0001, {15'h0, logic_result_bit});
    end
    do_op(plc_supp_pkg::OP_LOAD_SYS, plc_supp_pkg::AREA_SYSTEM, 8'h01, 4'h0, 16'h1111);
    chk("load outside fb", 16'h0001, {15'h0, s_inv & ~s_rd});
    chk("refused accu", 16'hA5C3, accu);
    in_fb = 1'b1;
    $display("load and skip done");
  endtask

  task automatic t_refuse;
    do_op(plc_supp_pkg::OP_SET_BIT, plc_supp_pkg::AREA_SYSTEM, 8'h01, 4'h1, 16'h0000);
    chk("set on system", 16'h0001, {15'h0, s_inv & ~s_rd});
    do_op(plc_supp_pkg::OP_TEST_ONE, plc_supp_pkg::AREA_TIMER, 8'h80, 4'h0, 16'h0001);
    chk("timer word 128", 16'h0001, {15'h0, s_inv});
    do_op(plc_supp_pkg::OP_ENABLE, plc_supp_pkg::AREA_DATA, 8'h01, 4'h0, 16'h0000);
    chk("enable on data", 16'h0001, {15'h0, s_inv});
    do_op(plc_supp_pkg::OP_ENABLE, plc_supp_pkg::AREA_COUNTER, 8'h80, 4'h0, 16'h0000);
    chk("enable word 128", 16'h0001, {15'h0, s_inv});
    do_op(4'h9, plc_supp_pkg::AREA_DATA, 8'h01, 4'h0, 16'h0000);
    chk("unknown code", 16'h0001, {15'h0, s_inv & ~s_rd});
    $display("refusals done");
  endtask

  task automatic t_enable;
    tc_start = 1'b1;
    set_rlo(1'b0);
    do_op(plc_supp_pkg::OP_ENABLE, plc_supp_pkg::AREA_TIMER, 8'h02, 4'h0, 16'h0000);
    chk("enable rlo low", 16'h0000, {15'h0, s_tc});
    set_rlo(1'b1);
    do_op(plc_supp_pkg::OP_ENABLE, plc_supp_pkg::AREA_COUNTER, 8'h7F, 4'h0, 16'h0000);
    chk("enable rising", 16'h0001, {15'h0, s_tc});
    chk("enable target", 16'h00FF, {8'h0, s_cnt, s_num});
    do_op(plc_supp_pkg::OP_ENABLE, plc_supp_pkg::AREA_COUNTER, 8'h7F, 4'h0, 16'h0000);
    chk("enable no edge", 16'h0000, {15'h0, s_tc});
    set_rlo(1'b0);
    do_op(plc_supp_pkg::OP_ENABLE, plc_supp_pkg::AREA_TIMER, 8'h05, 4'h0, 16'h0000);
    set_rlo(1'b1);
    tc_start = 1'b0;
    do_op(plc_supp_pkg::OP_ENABLE, plc_supp_pkg::AREA_TIMER, 8'h05, 4'h0, 16'h0000);
    chk("enable start low", 16'h0000, {15'h0, s_tc});
    $display("enable done");
  endtask

  task automatic t_halt(input logic by_prog);
    do_op(plc_supp_pkg::OP_HALT, plc_supp_pkg::AREA_DATA, 8'h00, 4'h0, 16'h0000);
    chk("halt pending", 16'h0001, {15'h0, pend});
    do_op(plc_supp_pkg::OP_NO_EFFECT, plc_supp_pkg::AREA_DATA, 8'h00, 4'h0, 16'h0000);
    chk("scan goes on", 16'h0003, {14'h0, s_done, running});
    scan_end = 1'b1;
    @(posedge clk); #1;
    scan_end = 1'b0;
    chk("stopped", 16'h0000, {15'h0, running});
    chk("stop cause", {8'h00, plc_supp_pkg::CAUSE_PROGRAM_STOP}, {8'h00, cause});
    op_valid = 1'b1;
    s_done = 1'b0;
    repeat (4) begin
      @(posedge clk); #1;
      if (done === 1'b1) s_done = 1'b1;
    end
    op_valid = 1'b0;
    chk("nothing taken stopped", 16'h0000, {15'h0, s_done});
    if (by_prog) prog_run = 1'b1;
    else sel_run = 1'b1;
    @(posedge clk); #1;
    {prog_run, sel_run} = 2'b00;
    chk("restarted", 16'h0001, {15'h0, running});
    $display("halt done");
  endtask

  initial begin
    #20000;
    errors++;
    final_report();
  end

  initial begin
    errors = 0;
    checks_done = 0;
    {arst_n, op_valid, scan_end, sel_run, prog_run, rlo_wr, rlo_in, tc_start} = '0;
    in_fb = 1'b1;
    op_code = 4'h0; op_area = 2'h0; op_word = 8'h00; op_bit = 4'h0; mem_rdata = 16'h0000;
    repeat (12) @(posedge clk);
    #1;
    arst_n = 1'b1;
    chk("reset state", 16'h0080, {cause, running, logic_result_bit, busy, accu[4:0]});
    t_bit_tests();
    t_set_clear();
    t_load_skip();
    t_refuse();
    t_enable();
    t_halt(1'b0);
    t_halt(1'b1);
    final_report();
  end
endmodule
`default_nettype wire
